// [design/ssr_params.svh]
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// register word indices, byte address is four times the index
`define SSR_IDX_INT_CTRL      4'h0
`define SSR_IDX_FLAGS         4'h1
`define SSR_IDX_ENABLES       4'h2
`define SSR_IDX_PRIORITY      4'h3
`define SSR_IDX_RX_STAT       4'h4
`define SSR_IDX_RX_BUF        4'h5
`define SSR_IDX_TX_STAT       4'h6
`define SSR_IDX_BAUD_CTRL     4'h7
`define SSR_IDX_DIV_HIGH      4'h8
`define SSR_IDX_DIV_LOW       4'h9
`define SSR_REG_CNT           10

// field positions
`define SSR_BIT_GLOBAL_IE     7
`define SSR_BIT_PERIPH_IE     6
`define SSR_BIT_RX_COMPLETE   5
`define SSR_BIT_PORT_EN       7
`define SSR_BIT_NINE_SEL      6
`define SSR_BIT_SINGLE_EN     5
`define SSR_BIT_CONT_EN       4
`define SSR_BIT_FRAME_ERR     2
`define SSR_BIT_OVERRUN       1
`define SSR_BIT_NINTH         0
`define SSR_BIT_CLK_SRC       7
`define SSR_BIT_SYNC_MODE     4
`define SSR_BIT_CLK_POL       4

// writable bits and reset values
`define SSR_RX_STAT_WMASK     8'hf8
`define SSR_FULL_WMASK        8'hff
`define SSR_NONE_WMASK        8'h00
`define SSR_RST_BYTE          8'h00
`define SSR_NINTH_POS         8
`define SSR_SYNC_STAGES       2

`endif

// [design/ssr_pkg.sv]
package ssr_pkg;
	typedef logic [7:0]  ssr_byte_t;
	typedef logic [8:0]  ssr_word_t;
	typedef logic [31:0] ssr_data_t;
	typedef logic [3:0]  ssr_cnt_t;
endpackage

// [design/ssr_shift.sv]
`timescale 1ns/1ps
`include "ssr_params.svh"
module ssr_shift #(
	parameter int SYNC_STAGES = `SSR_SYNC_STAGES
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	input  wire logic               link_clk_i,
	input  wire logic               link_dat_i,
	input  wire logic               enable_i,
	input  wire logic               clk_pol_i,
	input  wire logic               nine_i,
	output ssr_pkg::ssr_word_t      word_o,
	output logic                    done_o
);
	import ssr_pkg::*;

	if (SYNC_STAGES < 2) begin : g_bad_stages
		$error("SYNC_STAGES must be at least 2");
	end

	logic [SYNC_STAGES-1:0] clk_sync;
	logic [SYNC_STAGES-1:0] next_clk_sync;
	logic [SYNC_STAGES-1:0] dat_sync;
	logic [SYNC_STAGES-1:0] next_dat_sync;
	logic                   clk_prev;
	logic                   next_clk_prev;
	ssr_cnt_t               bit_cnt;
	ssr_cnt_t               next_bit_cnt;
	ssr_cnt_t               last_bit;
	ssr_word_t              next_word;
	logic                   next_done;
	logic                   edge_hit;
	logic                   clk_s;
	logic                   dat_s;

	assign clk_s = clk_sync[SYNC_STAGES-1];
	assign dat_s = dat_sync[SYNC_STAGES-1];

	always_comb begin
		next_clk_sync = {clk_sync[SYNC_STAGES-2:0], link_clk_i};
		next_dat_sync = {dat_sync[SYNC_STAGES-2:0], link_dat_i};
		next_clk_prev = clk_s;
		// active edge picked by polarity
		edge_hit = clk_pol_i ? (clk_prev & ~clk_s) : (~clk_prev & clk_s);
		last_bit = nine_i ? 4'h8 : 4'h7;
		next_bit_cnt = bit_cnt;
		next_word = word_o;
		next_done = 1'b0;
		if (!enable_i) begin
			next_bit_cnt = 4'h0;
		end else if (edge_hit) begin
			if (bit_cnt == 4'h0) begin
				next_word = '0;
			end
			next_word[bit_cnt] = dat_s;
			if (bit_cnt == last_bit) begin
				next_bit_cnt = 4'h0;
				next_done = 1'b1;
			end else begin
				next_bit_cnt = bit_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_sync <= '0;
			dat_sync <= '0;
			clk_prev <= 1'b0;
			bit_cnt  <= 4'h0;
			word_o   <= '0;
			done_o   <= 1'b0;
		end else if (ce_i) begin
			clk_sync <= next_clk_sync;
			dat_sync <= next_dat_sync;
			clk_prev <= next_clk_prev;
			bit_cnt  <= next_bit_cnt;
			word_o   <= next_word;
			done_o   <= next_done;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_EDGE_SAMPLE: assert property (
		ce_i && enable_i && edge_hit |=> word_o[$past(bit_cnt)] == $past(dat_s))
		else $error("bit not sampled on active edge");
	AST_NO_EDGE_HOLD: assert property (
		ce_i && enable_i && !edge_hit |=> word_o == $past(word_o) && !done_o)
		else $error("word changed without active edge");
endmodule

// [design/ssr_top.sv]
// Summary of operation
// - slave receive ignores single-receive enable; otherwise same as master receive
// - continuous receive keeps taking words while chip is in low power
// - completed word moves from shift register into receive buffer
// - enabled receive-complete during low power raises the wake request
// - nine-bit select gives nine data bits; ninth bit in receive status
// - completed word sets flag; interrupt only with receive interrupt enable
// - receive buffer read returns the low eight data bits
// - clearing continuous receive enable clears the latched overrun error
// - interrupt reaches the core only with global and peripheral enables set
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "ssr_params.svh"
module ssr_top #(
	parameter int ADR_W = 8
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  ssr_pkg::ssr_data_t      wb_dat_i,
	output ssr_pkg::ssr_data_t      wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               link_clk_i,
	input  wire logic               link_dat_i,
	input  wire logic               low_power_i,
	output logic                    irq_o,
	output logic                    wake_o
);
	import ssr_pkg::*;

	if (ADR_W < 6) begin : g_bad_adr
		$error("ADR_W must be at least 6");
	end

	function automatic logic is_reg(input logic [ADR_W-1:0] adr, input logic [3:0] idx);
		is_reg = (adr[1:0] == 2'b00) && (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
	endfunction

	function automatic ssr_byte_t wr_mask(input logic [3:0] idx);
		case (idx)
			`SSR_IDX_FLAGS:   wr_mask = `SSR_NONE_WMASK;
			`SSR_IDX_RX_BUF:  wr_mask = `SSR_NONE_WMASK;
			`SSR_IDX_RX_STAT: wr_mask = `SSR_RX_STAT_WMASK;
			default:          wr_mask = `SSR_FULL_WMASK;
		endcase
	endfunction

	// register storage
	ssr_byte_t  cfg [`SSR_REG_CNT];
	ssr_byte_t  next_cfg [`SSR_REG_CNT];
	ssr_byte_t  rx_buf;
	ssr_byte_t  next_rx_buf;
	logic       buf_full;
	logic       next_buf_full;
	logic       ninth;
	logic       next_ninth;
	logic       overrun;
	logic       next_overrun;
	logic       rx_flag;
	logic       next_rx_flag;
	logic       next_irq;
	logic       next_wake;
	ssr_data_t  next_dat;
	logic       next_ack;

	// bus decode
	logic       req;
	logic       fin;
	logic       hit;
	logic       wr;
	logic       rd;
	logic       rd_buf;
	logic [3:0] idx;
	ssr_byte_t  rb;
	ssr_byte_t  mask;

	// receive control
	logic       port_en;
	logic       cont_en;
	logic       sync_mode;
	logic       clk_src;
	logic       clk_pol;
	logic       nine_sel;
	logic       rx_ie;
	logic       global_ie;
	logic       periph_ie;
	logic       slave_rx;
	logic       accept;
	logic       flag_clr;
	ssr_word_t  shift_word;
	logic       shift_done;

	assign port_en   = cfg[`SSR_IDX_RX_STAT][`SSR_BIT_PORT_EN];
	assign cont_en   = cfg[`SSR_IDX_RX_STAT][`SSR_BIT_CONT_EN];
	assign nine_sel  = cfg[`SSR_IDX_RX_STAT][`SSR_BIT_NINE_SEL];
	assign sync_mode = cfg[`SSR_IDX_TX_STAT][`SSR_BIT_SYNC_MODE];
	assign clk_src   = cfg[`SSR_IDX_TX_STAT][`SSR_BIT_CLK_SRC];
	assign clk_pol   = cfg[`SSR_IDX_BAUD_CTRL][`SSR_BIT_CLK_POL];
	assign rx_ie     = cfg[`SSR_IDX_ENABLES][`SSR_BIT_RX_COMPLETE];
	assign global_ie = cfg[`SSR_IDX_INT_CTRL][`SSR_BIT_GLOBAL_IE];
	assign periph_ie = cfg[`SSR_IDX_INT_CTRL][`SSR_BIT_PERIPH_IE];

	// single-receive enable deliberately not used; low power does not stop
	assign slave_rx = port_en & sync_mode & ~clk_src & cont_en & ~overrun;

	ssr_shift #(
		.SYNC_STAGES (`SSR_SYNC_STAGES)
	) u_shift (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.link_clk_i (link_clk_i),
		.link_dat_i (link_dat_i),
		.enable_i   (slave_rx),
		.clk_pol_i  (clk_pol),
		.nine_i     (nine_sel),
		.word_o     (shift_word),
		.done_o     (shift_done)
	);

	// bus decode and readback
	always_comb begin
		// request taken while ack low; read data registered then
		req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		// writes and flag clear land on the edge that samples ack high
		// keep ce_i high while ack stands, or the write is lost
		fin = wb_cyc_i & wb_stb_i & wb_ack_o;
		idx = wb_adr_i[5:2];
		hit = (wb_adr_i[1:0] == 2'b00) &&
			(wb_adr_i[ADR_W-1:2] < (ADR_W-2)'(`SSR_REG_CNT));
		wr = fin & wb_we_i & wb_sel_i[0] & hit;
		rd = req & ~wb_we_i & hit;
		rd_buf = req & ~wb_we_i & is_reg(wb_adr_i, `SSR_IDX_RX_BUF);
		flag_clr = fin & wb_we_i & wb_sel_i[0] & is_reg(wb_adr_i, `SSR_IDX_FLAGS) &
			wb_dat_i[`SSR_BIT_RX_COMPLETE];
		mask = wr_mask(idx);
		rb = `SSR_RST_BYTE;
		if (hit) begin
			case (idx)
				`SSR_IDX_FLAGS: begin
					rb[`SSR_BIT_RX_COMPLETE] = rx_flag;
				end
				`SSR_IDX_RX_STAT: begin
					rb = cfg[idx] & `SSR_RX_STAT_WMASK;
					rb[`SSR_BIT_FRAME_ERR] = 1'b0;
					rb[`SSR_BIT_OVERRUN] = overrun;
					rb[`SSR_BIT_NINTH] = ninth;
				end
				`SSR_IDX_RX_BUF: begin
					rb = rx_buf;
				end
				default: begin
					rb = cfg[idx];
				end
			endcase
		end
		next_ack = req;
		next_dat = rd ? {24'h000000, rb} : 32'h00000000;
	end

	// configuration writes
	always_comb begin
		next_cfg = cfg;
		if (wr) begin
			next_cfg[idx] = (cfg[idx] & ~mask) | (wb_dat_i[7:0] & mask);
		end
	end

	// receive data path, flags and interrupt
	always_comb begin
		accept = shift_done & (~buf_full | rd_buf);
		next_rx_buf = rx_buf;
		next_ninth = ninth;
		next_buf_full = buf_full;
		next_overrun = overrun;
		if (accept) begin
			next_rx_buf = shift_word[7:0];
			next_ninth = nine_sel & shift_word[`SSR_NINTH_POS];
			next_buf_full = 1'b1;
		end else if (rd_buf) begin
			next_buf_full = 1'b0;
		end
		if (!cont_en) begin
			next_overrun = 1'b0;
		end else if (shift_done && !accept) begin
			next_overrun = 1'b1;
		end
		// set wins over a same-cycle clear
		next_rx_flag = accept | (rx_flag & ~flag_clr);
		next_irq = rx_flag & rx_ie & global_ie & periph_ie;
		next_wake = rx_flag & rx_ie & low_power_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `SSR_REG_CNT; i++) begin
				cfg[i] <= `SSR_RST_BYTE;
			end
			rx_buf   <= `SSR_RST_BYTE;
			buf_full <= 1'b0;
			ninth    <= 1'b0;
			overrun  <= 1'b0;
			rx_flag  <= 1'b0;
			irq_o    <= 1'b0;
			wake_o   <= 1'b0;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			cfg      <= next_cfg;
			rx_buf   <= next_rx_buf;
			buf_full <= next_buf_full;
			ninth    <= next_ninth;
			overrun  <= next_overrun;
			rx_flag  <= next_rx_flag;
			irq_o    <= next_irq;
			wake_o   <= next_wake;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_SINGLE_IGNORED: assert property (
		port_en && sync_mode && !clk_src && cont_en && !overrun |-> slave_rx)
		else $error("receiver gated by something other than its enables");
	AST_LOWPOWER_RX: assert property (
		ce_i && low_power_i && shift_done && !buf_full |=> buf_full && rx_flag)
		else $error("word lost during low power");
	AST_BUF_LOAD: assert property (
		ce_i && shift_done && !buf_full |=> rx_buf == $past(shift_word[7:0]))
		else $error("receive buffer not loaded from shift register");
	AST_WAKE: assert property (
		ce_i && low_power_i && rx_flag && rx_ie |=> wake_o)
		else $error("wake not raised");
	AST_NINTH: assert property (
		ce_i && shift_done && !buf_full && nine_sel
		|=> ninth == $past(shift_word[`SSR_NINTH_POS]))
		else $error("ninth bit not captured");
	AST_NO_RX_DISABLED: assert property (
		(ce_i && !cont_en) ##1 (ce_i && !cont_en) |=> !shift_done)
		else $error("word taken while continuous receive off");
	AST_FLAG_SET: assert property (
		ce_i && accept |=> rx_flag ##1
		(!$past(ce_i) || irq_o == $past(rx_ie && global_ie && periph_ie)))
		else $error("flag or interrupt wrong after word");
	AST_BUF_LOW8: assert property (
		ce_i && rd_buf |=> wb_ack_o && wb_dat_o == {24'h000000, $past(rx_buf)})
		else $error("buffer read data wrong");
	AST_ERR_CLEAR: assert property (
		ce_i && !cont_en |=> !overrun)
		else $error("overrun not cleared");
	AST_IRQ_GATED: assert property (
		$rose(irq_o) |-> $past(rx_flag && rx_ie && global_ie && periph_ie))
		else $error("interrupt without all enables");
	AST_ACK_ANSWER: assert property (
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	AST_ACK_PULSE: assert property (
		ce_i && wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_HIGH_ZERO: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read data not zero");
	AST_RO_BUF: assert property (
		ce_i && wr && !accept |=> rx_buf == $past(rx_buf))
		else $error("receive buffer changed by a write");
	AST_FLAG_CLEAR: assert property (
		ce_i && flag_clr && !accept |=> !rx_flag)
		else $error("flag not cleared by write of one");
	AST_FLAG_HOLD: assert property (
		ce_i && rx_flag && !flag_clr |=> rx_flag)
		else $error("flag dropped without clear");
	AST_OVERRUN_SET: assert property (
		ce_i && cont_en && shift_done && buf_full && !rd_buf |=> overrun && rx_buf == $past(rx_buf))
		else $error("overrun not flagged or buffer overwritten");
	AST_POP: assert property (
		ce_i && rd_buf && !shift_done |=> !buf_full)
		else $error("buffer not emptied by read");
	AST_WAKE_OFF: assert property (
		ce_i && !low_power_i |=> !wake_o)
		else $error("wake outside low power");
	AST_IRQ_MASKED: assert property (
		ce_i && !(global_ie && periph_ie) |=> !irq_o)
		else $error("interrupt while masked");
	AST_NINTH_CLR: assert property (
		ce_i && accept && !nine_sel |=> !ninth)
		else $error("ninth bit set in eight-bit mode");

	COV_WORD8: cover property (ce_i && accept && !nine_sel);
	COV_WORD9: cover property (ce_i && accept && nine_sel && shift_word[`SSR_NINTH_POS]);
	COV_OVERRUN: cover property ($rose(overrun));
	COV_WAKE: cover property ($rose(wake_o));
	COV_IRQ: cover property ($rose(irq_o));
endmodule

// [verification/ssr_link_master.sv]
`timescale 1ns/1ps
module ssr_link_master (
	output logic link_clk_o,
	output logic link_dat_o
);
	initial begin
		link_clk_o = 1'b0;
		link_dat_o = 1'b0;
	end
	// idle level, changed only while the receiver is off
	task automatic set_idle(input logic pol);
		link_clk_o = pol;
	endtask
	// lsb first, data held a half period past the active edge
	task automatic send(input logic [8:0] w, input int n, input logic pol, input int h);
		#1.3;
		for (int i = 0; i < n; i++) begin
			link_dat_o = w[i];
			#(h);
			link_clk_o = ~pol;
			#(h);
			link_clk_o = pol;
		end
		link_dat_o = ~w[n-1];
	endtask
endmodule

// [verification/ssr_top_tb.sv]
`timescale 1ns/1ps
`include "ssr_params.svh"
module ssr_top_tb;
	import ssr_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, low_power_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	ssr_data_t  wb_dat_i, wb_dat_o, q;
	logic       wb_ack_o, irq_o, wake_o, link_clk, link_dat;
	int         failures, check_count;
	ssr_word_t  w;
	ssr_byte_t  v;

	always #2 clk_i = ~clk_i;

	ssr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.link_clk_i(link_clk), .link_dat_i(link_dat), .low_power_i(low_power_i),
		.irq_o(irq_o), .wake_o(wake_o));
	ssr_link_master i_link (.link_clk_o(link_clk), .link_dat_o(link_dat));

	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check_reg(input ssr_data_t got, input ssr_data_t exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp);
		check_reg({31'h0, got}, {31'h0, exp});
	endtask

	task automatic xfer(input logic we, input logic [7:0] a, input ssr_byte_t d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			stop_test();
		end else begin
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input ssr_byte_t d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input ssr_byte_t exp, input ssr_byte_t m);
		xfer(1'b0, a, 8'h00);
		check_reg(q & {24'h0, m}, {24'h0, exp & m});
	endtask

	function automatic ssr_byte_t wmask(input int i);
		case (i)
			1, 5: wmask = `SSR_NONE_WMASK;
			4: wmask = `SSR_RX_STAT_WMASK;
			default: wmask = `SSR_FULL_WMASK;
		endcase
	endfunction

	function automatic ssr_byte_t stat(input ssr_byte_t c, input logic ov, input logic b9);
		stat = (c & `SSR_RX_STAT_WMASK) | {6'h0, ov, b9};
	endfunction

	task automatic cfg(input logic pol, input logic nine, input logic sgl);
		wr(8'h10, 8'h00);
		i_link.set_idle(pol);
		wr(8'h1c, {3'h0, pol, 4'h0});
		wr(8'h18, 8'h10);
		wr(8'h08, 8'h20);
		wr(8'h00, 8'hc0);
		wr(8'h10, {1'b1, nine, sgl, 1'b1, 4'h0});
	endtask

	task automatic recv(input ssr_word_t x, input int n, input logic pol, input int h);
		i_link.send(x, n, pol, h);
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		low_power_i = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = '0;
		void'($urandom(32'hd105));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i <= 10; i++) rd(8'(i * 4), 8'h00, 8'hff);
		rd(8'h11, 8'h00, 8'hff);
		for (int i = 0; i < 10; i++) begin
			v = 8'($urandom);
			wr(8'(i * 4), v);
			rd(8'(i * 4), v & wmask(i), 8'hff);
			wr(8'(i * 4), 8'h00);
		end
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			cfg(k[0], k[1], k[2]);
			w = 9'($urandom);
			recv(w, k[1] ? 9 : 8, k[0], 40);
			check_pin(irq_o, 1'b1);
			rd(8'h04, 8'h20, 8'hff);
			v = stat({1'b1, k[1], k[2], 5'h10}, 1'b0, w[8]);
			rd(8'h10, v, k[1] ? 8'hff : 8'hfe);
			rd(8'h14, w[7:0], 8'hff);
			wr(8'h04, 8'h20);
			repeat (2) @(posedge clk_i);
			check_pin(irq_o, 1'b0);
		end
		$display("test receive done");
		cfg(1'b0, 1'b0, 1'b0);
		wr(8'h00, 8'h40);
		low_power_i <= 1'b1;
		w = 9'($urandom);
		fork
			recv(w, 8, 1'b0, 40);
			begin
				repeat (30) @(posedge clk_i);
				ce_i <= 1'b0;
				repeat (3) @(posedge clk_i);
				ce_i <= 1'b1;
			end
		join
		check_pin(irq_o, 1'b0);
		check_pin(wake_o, 1'b1);
		wr(8'h08, 8'h00);
		repeat (2) @(posedge clk_i);
		check_pin(wake_o, 1'b0);
		rd(8'h14, w[7:0], 8'hff);
		wr(8'h04, 8'h20);
		low_power_i <= 1'b0;
		wr(8'h10, 8'ha0);
		recv(9'h0a5, 8, 1'b0, 40);
		rd(8'h04, 8'h00, 8'hff);
		$display("test gating done");
		cfg(1'b0, 1'b0, 1'b0);
		w = 9'($urandom);
		recv(w, 8, 1'b0, 40);
		recv(~w, 8, 1'b0, 40);
		rd(8'h10, stat(8'h90, 1'b1, 1'b0), 8'hfe);
		rd(8'h14, w[7:0], 8'hff);
		wr(8'h04, 8'h20);
		wr(8'h10, 8'h80);
		rd(8'h10, 8'h80, 8'hfe);
		wr(8'h10, 8'h90);
		recv(~w, 8, 1'b0, 40);
		rd(8'h14, ~w[7:0], 8'hff);
		$display("test overrun done");
		stop_test();
	end
endmodule
